// ---- fpu_core_model.sv ----
// fpu_core_model: execution core side, data registers and live words
// assumes: the testbench sets register contents through put()
`timescale 1ns/1ps
`default_nettype none
module fpu_core_model (
   output logic [639:0] reg_contents, // all data registers
   output logic [15:0]  status_word,  // live status word
   output logic [15:0]  control_word  // live control word
);
   logic [79:0] regs [8];

   // every register starts as a normal number, exponent bias, integer set
   initial begin
      for (int i = 0; i < 8; i++) begin
         regs[i] = {1'b0, 15'h3fff, 1'b1, 63'(i)};
      end
   end

   // registers hold extended-real values only
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         reg_contents[i*80+:80] = regs[i];
      end
   end

   // bit 12 set on purpose: it must not change infinity handling
   assign status_word  = 16'h3800;
   assign control_word = 16'h137f;

   task automatic put(input int idx, input logic [79:0] v);
      regs[idx] = v;
   endtask
endmodule
`default_nettype wire

// ---- fpu_env_pkg.sv ----
// fpu_env_pkg: constants and types for the tag, pointer and opcode state
// assumes: shared by the environment state module and its testbench
package fpu_env_pkg;

   // tag word shape
   localparam int          NUM_REGS        = 8;
   localparam int          TAG_W           = 2;
   localparam int          TAG_WORD_W      = 16;
   localparam logic [15:0] TAG_WORD_INIT   = 16'hffff;
   localparam logic [1:0]  TAG_VALID       = 2'h0;
   localparam logic [1:0]  TAG_ZERO        = 2'h1;
   localparam logic [1:0]  TAG_SPECIAL     = 2'h2;
   localparam logic [1:0]  TAG_EMPTY       = 2'h3;

   // pointer layout: offset low, selector high
   localparam int          PTR_W           = 48;
   localparam int          OFFSET_LSB      = 0;
   localparam int          OFFSET_MSB      = 31;
   localparam int          SEL_LSB         = 32;
   localparam int          SEL_MSB         = 47;
   localparam logic [47:0] PTR_RESET       = 48'h0;

   // opcode record
   localparam int          OPC_W           = 11;
   localparam int          OPC_LOW_BITS    = 3;
   localparam logic [4:0]  OPC_FIXED_HIGH  = 5'h1b;
   localparam logic [10:0] OPC_RESET       = 11'h0;

   // extended-real register fields
   localparam int          EXT_W           = 80;
   localparam int          EXP_MSB         = 78;
   localparam int          EXP_LSB         = 64;
   localparam int          INT_BIT         = 63;
   localparam logic [14:0] EXP_MAX         = 15'h7fff;
   localparam logic [14:0] EXP_MIN         = 15'h0;

   // operations issued by the execution core
   typedef enum logic [3:0] {
      CMD_EXEC    = 4'h0,  // non-control, no stack move
      CMD_PUSH    = 4'h1,  // non-control load / push
      CMD_POP     = 4'h2,  // non-control store / pop
      CMD_INIT    = 4'h3,
      CMD_CLEX    = 4'h4,
      CMD_LDCW    = 4'h5,
      CMD_STCW    = 4'h6,
      CMD_STSW    = 4'h7,
      CMD_STENV   = 4'h8,
      CMD_LDENV   = 4'h9,
      CMD_SAVE    = 4'ha,
      CMD_RESTORE = 4'hb,
      CMD_WAIT    = 4'hc
   } cmd_type;

   // saved image layouts
   typedef enum logic [1:0] {
      LAYOUT_PROT32 = 2'h0,
      LAYOUT_PROT16 = 2'h1,
      LAYOUT_REAL32 = 2'h2,
      LAYOUT_REAL16 = 2'h3
   } layout_type;

endpackage

// ---- fpu_tag_pointer_state.sv ----
// fpu_tag_pointer_state: tag word, instruction/operand pointers, opcode
// record, stack overflow/underflow detection and environment save/load.
// assumes: the execution core sits on the same clock, supplies the stack
// top pointer, register contents and image words, and issues one operation
// per cycle with op_valid.
// no operation stalls; each one completes on the edge that takes it.
// register contents must be settled when an image load is taken.
// no register bus: all access is by core operations.
`timescale 1ns/1ps
`default_nettype none

module fpu_tag_pointer_state #(
   parameter int NUM_REGS = fpu_env_pkg::NUM_REGS  // data stack depth
) (
   input  wire logic                 clk,             // core clock
   input  wire logic                 rst_b,           // async reset, low
   // operation from the execution core
   input  wire logic                 op_valid,        // operation this cycle
   input  wire fpu_env_pkg::cmd_type op_cmd,          // operation kind
   input  wire logic [2:0]           stack_top,       // top from status
   input  wire logic                 src_valid,       // source operand used
   input  wire logic [2:0]           src_rel,         // source, stack-relative
   input  wire logic                 result_we,       // exec writes a register
   input  wire logic [2:0]           result_rel,      // written, stack-relative
   input  wire logic [79:0]          result_value,    // value written / pushed
   input  wire logic [639:0]         reg_contents,    // all data registers
   // addresses and opcode of the current operation
   input  wire logic [31:0]          prefix_offset,   // first prefix offset
   input  wire logic [15:0]          code_selector,   // code segment selector
   input  wire logic                 has_mem_operand, // memory operand present
   input  wire logic [31:0]          operand_offset,  // operand start offset
   input  wire logic [15:0]          operand_selector,// operand selector
   input  wire logic [7:0]           opcode_first,    // first byte after prefix
   input  wire logic [7:0]           opcode_second,   // second opcode byte
   input  wire logic [15:0]          status_word,     // live status word
   input  wire logic [15:0]          control_word,    // live control word
   // image words for the two load operations
   input  wire logic [15:0]          image_tag,       // loaded tag image
   input  wire logic [47:0]          image_instr_ptr, // loaded instr pointer
   input  wire logic [47:0]          image_oper_ptr,  // loaded oper pointer
   input  wire logic [10:0]          image_opcode,    // loaded opcode record
   // mode and operand size pick the layout
   input  wire logic                 prot_mode,       // protected mode
   input  wire logic                 v86_mode,        // virtual-8086 mode
   input  wire logic                 system_management_mode, // mgmt mode
   input  wire logic                 op32,            // 32-bit operand size
   // registered pulses and save image
   output logic                      overflow_pulse,  // stack overflow
   output logic                      underflow_pulse, // stack underflow
   output logic                      save_valid,      // image words valid
   output logic                      save_with_data,  // data regs follow
   output logic                      reload_data,     // restore data regs
   output fpu_env_pkg::layout_type   save_layout,     // image layout
   output logic [15:0]               save_status,     // saved status word
   output logic [15:0]               save_control,    // saved control word
   output logic [15:0]               save_tag_word,   // saved tag word
   output logic [47:0]               save_instr_ptr,  // saved instr pointer
   output logic [47:0]               save_oper_ptr,   // saved oper pointer
   output logic [10:0]               save_opcode      // saved opcode record
);

   // classify one extended-real value into its tag; control bit 12 is
   // deliberately not an input, so infinity handling cannot depend on it
   // zero: exponent and significand clear
   // special: denormal, infinity, nan, or
   // a clear integer bit (unsupported)
   // valid: normal finite numbers
   function automatic logic [1:0] classify(input logic [79:0] v);
      logic [14:0] ex;
      logic [1:0]  t;
      ex = v[fpu_env_pkg::EXP_MSB:fpu_env_pkg::EXP_LSB];
      if (ex == fpu_env_pkg::EXP_MIN && v[fpu_env_pkg::INT_BIT:0] == '0) begin
         t = fpu_env_pkg::TAG_ZERO;
      end else if (ex == fpu_env_pkg::EXP_MIN ||
                   ex == fpu_env_pkg::EXP_MAX ||
                   !v[fpu_env_pkg::INT_BIT]) begin
         t = fpu_env_pkg::TAG_SPECIAL;
      end else begin
         t = fpu_env_pkg::TAG_VALID;
      end
      return t;
   endfunction

   // stack-relative position to physical register number
   // wraps at eight: top minus one is top plus seven
   function automatic logic [2:0] phys(input logic [2:0] top,
                                       input logic [2:0] rel);
      return 3'(top + rel);
   endfunction

   // pack offset and selector into a 48-bit pointer, offset in low bits
   // the two fields fill all 48 bits
   function automatic logic [47:0] pack_ptr(input logic [31:0] off,
                                            input logic [15:0] sel);
      logic [47:0] p;
      p = fpu_env_pkg::PTR_RESET;
      p[fpu_env_pkg::OFFSET_MSB:fpu_env_pkg::OFFSET_LSB] = off;
      p[fpu_env_pkg::SEL_MSB:fpu_env_pkg::SEL_LSB]       = sel;
      return p;
   endfunction

   // state seen only through a saved image
   logic [15:0] tag_word_ff;
   logic [15:0] nxt_tag_word;
   logic [47:0] instr_ptr_ff;
   logic [47:0] oper_ptr_ff;
   logic [10:0] opcode_ff;
   // derived signals, all combinational
   logic [1:0]  reg_class [NUM_REGS];
   logic        is_noncontrol;
   logic        is_reinit;
   logic        is_envload;
   logic        is_store;
   logic [2:0]  push_slot;
   logic [2:0]  pop_slot;
   logic [2:0]  src_slot;
   logic [2:0]  res_slot;
   logic [1:0]  result_tag;
   logic        nxt_overflow;
   logic        nxt_underflow;
   fpu_env_pkg::layout_type nxt_layout;

   // operation groups
   // only exec, push and pop are non-control;
   // init and save clear the pointers, the two loads load them, all other control commands hold them
   assign is_noncontrol = op_valid && (op_cmd == fpu_env_pkg::CMD_EXEC ||
                                       op_cmd == fpu_env_pkg::CMD_PUSH ||
                                       op_cmd == fpu_env_pkg::CMD_POP);
   assign is_reinit     = op_valid && (op_cmd == fpu_env_pkg::CMD_INIT ||
                                       op_cmd == fpu_env_pkg::CMD_SAVE);
   assign is_envload    = op_valid && (op_cmd == fpu_env_pkg::CMD_LDENV ||
                                       op_cmd == fpu_env_pkg::CMD_RESTORE);
   assign is_store      = op_valid && (op_cmd == fpu_env_pkg::CMD_STENV ||
                                       op_cmd == fpu_env_pkg::CMD_SAVE);

   // physical slots touched this cycle
   // all use the top before the operation
   assign push_slot  = phys(stack_top, 3'h7);   // top minus one
   assign pop_slot   = phys(stack_top, 3'h1);   // top plus one
   assign src_slot   = phys(stack_top, src_rel);
   assign res_slot   = phys(stack_top, result_rel);
   assign result_tag = classify(result_value);

   // per-register class of the actual contents, for image loads
   // eight classifiers cost area but let
   // a load settle in a single cycle
   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS; gi++) begin : g_class
         assign reg_class[gi] = classify(reg_contents[gi*80 +: 80]);
      end
   endgenerate

   // stack fault detection from the tags before this cycle's update
   // an overflowing push still writes its tag
   // a pop checks the slot above the top
   always_comb begin
      nxt_overflow  = 1'b0;
      nxt_underflow = 1'b0;
      if (is_noncontrol && op_cmd == fpu_env_pkg::CMD_PUSH &&
          tag_word_ff[push_slot*2 +: 2] != fpu_env_pkg::TAG_EMPTY) begin
         nxt_overflow = 1'b1;
      end
      if (is_noncontrol && op_cmd == fpu_env_pkg::CMD_POP &&
          tag_word_ff[pop_slot*2 +: 2] == fpu_env_pkg::TAG_EMPTY) begin
         nxt_underflow = 1'b1;
      end
      if (is_noncontrol && src_valid &&
          tag_word_ff[src_slot*2 +: 2] == fpu_env_pkg::TAG_EMPTY) begin
         nxt_underflow = 1'b1;
      end
   end

   // next tag word; no operation writes a raw tag value from outside
   // reinit wins over image load, which wins
   // over ordinary operations
   always_comb begin
      nxt_tag_word = tag_word_ff;
      if (is_reinit) begin
         nxt_tag_word = fpu_env_pkg::TAG_WORD_INIT;
      end else if (is_envload) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            if (image_tag[i*2 +: 2] == fpu_env_pkg::TAG_EMPTY) begin
               nxt_tag_word[i*2 +: 2] = fpu_env_pkg::TAG_EMPTY;
            end else begin
               nxt_tag_word[i*2 +: 2] = reg_class[i];
            end
         end
      end else if (is_noncontrol) begin
         // a pop frees the old top before any result lands
         // and a push fills the slot below it
         if (op_cmd == fpu_env_pkg::CMD_POP) begin
            nxt_tag_word[stack_top*2 +: 2] = fpu_env_pkg::TAG_EMPTY;
         end
         if (op_cmd == fpu_env_pkg::CMD_PUSH) begin
            nxt_tag_word[push_slot*2 +: 2] = result_tag;
         end else if (result_we) begin
            nxt_tag_word[res_slot*2 +: 2] = result_tag;
         end
      end
   end

   // tag register; reset leaves every data register empty
   // (the value init and full save give)
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tag_word_ff <= fpu_env_pkg::TAG_WORD_INIT;
      end else begin
         tag_word_ff <= nxt_tag_word;
      end
   end

   // pointers and opcode move as one group, except that a non-control op without a memory operand keeps the old operand pointer, so a saved image
   // can mix two instructions; control operations other than init, save and the loads hold them
   // image loads are taken verbatim
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         instr_ptr_ff <= fpu_env_pkg::PTR_RESET;
         oper_ptr_ff  <= fpu_env_pkg::PTR_RESET;
         opcode_ff    <= fpu_env_pkg::OPC_RESET;
      end else if (is_reinit) begin
         instr_ptr_ff <= fpu_env_pkg::PTR_RESET;
         oper_ptr_ff  <= fpu_env_pkg::PTR_RESET;
         opcode_ff    <= fpu_env_pkg::OPC_RESET;
      end else if (is_envload) begin
         instr_ptr_ff <= image_instr_ptr;
         oper_ptr_ff  <= image_oper_ptr;
         opcode_ff    <= image_opcode;
      end else if (is_noncontrol) begin
         // prefix address, not opcode address, is recorded
         instr_ptr_ff <= pack_ptr(prefix_offset, code_selector);
         // without a memory operand the old value is kept; it means nothing
         // and software must not rely on it
         if (has_mem_operand) begin
            oper_ptr_ff <= pack_ptr(operand_offset,
                                    operand_selector);
         end
         // the fixed upper five bits of the first byte are not stored
         opcode_ff <= {opcode_first[fpu_env_pkg::OPC_LOW_BITS-1:0],
                       opcode_second};
      end
   end

   // fault pulses, one cycle after the operation is taken
   // registered: clean for the core, one cycle late
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         overflow_pulse  <= 1'b0;
         underflow_pulse <= 1'b0;
      end else begin
         overflow_pulse  <= nxt_overflow;
         underflow_pulse <= nxt_underflow;
      end
   end

   // layout choice; virtual-8086 and system management mode
   // fall back to the real-address layout
   always_comb begin
      if (prot_mode && !v86_mode && !system_management_mode) begin
         nxt_layout = op32 ? fpu_env_pkg::LAYOUT_PROT32
                           : fpu_env_pkg::LAYOUT_PROT16;
      end else begin
         nxt_layout = op32 ? fpu_env_pkg::LAYOUT_REAL32
                           : fpu_env_pkg::LAYOUT_REAL16;
      end
   end

   // save image capture; it snapshots the state before a full save
   // reinitialises it, since both happen on the same edge
   // words hold until the next store, so the
   // core may write them out over many cycles
   // this image is the only view of the tags
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         save_valid     <= 1'b0;
         save_with_data <= 1'b0;
         save_layout    <= fpu_env_pkg::LAYOUT_PROT32;
         save_status    <= '0;
         save_control   <= '0;
         save_tag_word  <= fpu_env_pkg::TAG_WORD_INIT;
         save_instr_ptr <= fpu_env_pkg::PTR_RESET;
         save_oper_ptr  <= fpu_env_pkg::PTR_RESET;
         save_opcode    <= fpu_env_pkg::OPC_RESET;
      end else begin
         save_valid     <= is_store;
         save_with_data <= is_store &&
                           op_cmd == fpu_env_pkg::CMD_SAVE;
         if (is_store) begin
            save_layout    <= nxt_layout;
            save_status    <= status_word;
            // bit 12 is passed through for compatibility only
            // and means nothing inside this block
            save_control   <= control_word;
            save_tag_word  <= tag_word_ff;
            // the core writes each word low byte first at its start address
            save_instr_ptr <= instr_ptr_ff;
            save_oper_ptr  <= oper_ptr_ff;
            save_opcode    <= opcode_ff;
         end
      end
   end

   // restore asks the core to reload the data registers too
   // (environment load leaves them alone)
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reload_data <= 1'b0;
      end else begin
         reload_data <= op_valid &&
                        op_cmd == fpu_env_pkg::CMD_RESTORE;
      end
   end

endmodule

`default_nettype wire

// ---- fpu_tag_pointer_state_props.sv ----
// fpu_tag_pointer_state_props: port-level checks of the environment state
// assumes: one clock domain, bound into every state module instance
`timescale 1ns/1ps
`default_nettype none
module fpu_tag_pointer_state_props (
   input wire logic                    clk,                    // core clock
   input wire logic                    rst_b,                  // reset, low
   input wire logic                    op_valid,               // op taken
   input wire fpu_env_pkg::cmd_type    op_cmd,                 // op kind
   input wire logic [31:0]             prefix_offset,          // ip offset
   input wire logic [15:0]             code_selector,          // ip selector
   input wire logic                    v86_mode,               // v86 mode
   input wire logic                    system_management_mode, // mgmt mode
   input wire logic                    op32,                   // 32-bit size
   input wire logic                    overflow_pulse,         // overflow
   input wire logic                    underflow_pulse,        // underflow
   input wire logic                    save_valid,             // image valid
   input wire logic                    save_with_data,         // data follows
   input wire logic                    reload_data,            // data reload
   input wire fpu_env_pkg::layout_type save_layout,            // layout
   input wire logic [15:0]             save_tag_word,          // saved tags
   input wire logic [47:0]             save_instr_ptr,         // saved ip
   input wire logic [47:0]             save_oper_ptr           // saved op ptr
);
   logic is_save, is_stenv, is_exec, is_push, is_nonctl, is_ctl;
   logic is_load, is_rest;

   // decoded operations keep the properties short
   assign is_save   = op_valid && op_cmd == fpu_env_pkg::CMD_SAVE;
   assign is_stenv  = op_valid && op_cmd == fpu_env_pkg::CMD_STENV;
   assign is_exec   = op_valid && op_cmd == fpu_env_pkg::CMD_EXEC;
   assign is_push   = op_valid && op_cmd == fpu_env_pkg::CMD_PUSH;
   assign is_rest   = op_valid && op_cmd == fpu_env_pkg::CMD_RESTORE;
   assign is_load   = is_rest
                      || (op_valid && op_cmd == fpu_env_pkg::CMD_LDENV);
   assign is_nonctl = is_exec || is_push
                      || (op_valid && op_cmd == fpu_env_pkg::CMD_POP);
   // init, save and loads change pointers on purpose, so they stay out
   assign is_ctl    = op_valid && op_cmd inside {fpu_env_pkg::CMD_CLEX,
                      fpu_env_pkg::CMD_LDCW, fpu_env_pkg::CMD_STCW,
                      fpu_env_pkg::CMD_STSW, fpu_env_pkg::CMD_WAIT};

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_save_with_data: assert property (
      is_save |=> save_valid && save_with_data)
      else $error("full save gave no image with data");
   a_stenv_env_only: assert property (
      is_stenv |=> save_valid && !save_with_data)
      else $error("environment store image wrong");
   a_reload_kind: assert property (
      is_load |=> reload_data == $past(is_rest))
      else $error("data reload flag wrong for load kind");
   a_save_reinit: assert property (
      is_save ##1 is_stenv |=> save_tag_word == 16'hffff
      && save_instr_ptr == 48'h0 && save_oper_ptr == 48'h0)
      else $error("state not reinitialised after full save");
   a_ptr_capture: assert property (
      is_exec ##1 is_stenv |=> save_instr_ptr ==
      {$past(code_selector, 2), $past(prefix_offset, 2)})
      else $error("instruction pointer not captured");
   a_ctrl_keeps_ptr: assert property (
      is_stenv ##1 is_ctl ##1 is_stenv |=>
      save_instr_ptr == $past(save_instr_ptr, 2)
      && save_oper_ptr == $past(save_oper_ptr, 2))
      else $error("control operation moved a pointer");
   a_layout_real: assert property (
      is_stenv && (v86_mode || system_management_mode) |=>
      save_layout == ($past(op32) ? fpu_env_pkg::LAYOUT_REAL32
                                  : fpu_env_pkg::LAYOUT_REAL16))
      else $error("v86 or management mode store used wrong layout");
   a_overflow_cause: assert property (
      overflow_pulse |-> $past(is_push))
      else $error("overflow without a push");
   a_underflow_cause: assert property (
      underflow_pulse |-> $past(is_nonctl))
      else $error("underflow without a stack operation");
endmodule
bind fpu_tag_pointer_state fpu_tag_pointer_state_props u_props (.*);
`default_nettype wire

// ---- fpu_tag_pointer_state_tb_top.sv ----
// fpu_tag_pointer_state_tb_top: directed tests of tags, pointers and images
// assumes: the core model answers at once, operations one per cycle
`timescale 1ns/1ps
`default_nettype none
module fpu_tag_pointer_state_tb_top;
   logic clk = 1'b0, rst_b = 1'b0, op_valid = 1'b0, src_valid = 1'b0;
   fpu_env_pkg::cmd_type op_cmd = fpu_env_pkg::CMD_EXEC;
   logic [2:0] stack_top = 3'h0, src_rel = 3'h0, result_rel = 3'h0;
   logic result_we = 1'b0, has_mem_operand = 1'b0, prot_mode = 1'b0;
   logic v86_mode = 1'b0, system_management_mode = 1'b0, op32 = 1'b0;
   logic [79:0] result_value = 80'h0;
   logic [31:0] prefix_offset = 32'h0, operand_offset = 32'h0;
   logic [15:0] code_selector = 16'h0, operand_selector = 16'h0;
   logic [15:0] image_tag = 16'hffff, status_word, control_word;
   logic [7:0] opcode_first = 8'h0, opcode_second = 8'h0;
   logic [47:0] image_instr_ptr = 48'h0, image_oper_ptr = 48'h0;
   logic [10:0] image_opcode = 11'h0, save_opcode;
   logic [639:0] reg_contents;
   logic overflow_pulse, underflow_pulse, save_valid, save_with_data;
   logic reload_data;
   fpu_env_pkg::layout_type save_layout;
   logic [15:0] save_status, save_control, save_tag_word;
   logic [47:0] save_instr_ptr, save_oper_ptr;
   int fail_count = 0, cmp_count = 0, cycles = 0;
   localparam logic [79:0] V_ONE = {1'b0, 15'h3fff, 1'b1, 63'h0};
   localparam logic [79:0] V_INF = {1'b0, 15'h7fff, 1'b1, 63'h0};
   localparam logic [47:0] IP_EXP = 48'h00c8_1234_5678;
   logic [3:0] mode_tab [6] = '{4'h9, 4'h8, 4'h1, 4'h0, 4'hd, 4'ha};
   logic [1:0] lay_tab [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h3};
   fpu_env_pkg::cmd_type ctl_tab [5] = '{fpu_env_pkg::CMD_CLEX,
      fpu_env_pkg::CMD_LDCW, fpu_env_pkg::CMD_STCW, fpu_env_pkg::CMD_STSW,
      fpu_env_pkg::CMD_WAIT};

   fpu_tag_pointer_state DUT (.*);
   fpu_core_model CORE (.reg_contents(reg_contents),
      .status_word(status_word), .control_word(control_word));

   // 40 MHz core clock
   always #12.5 clk = ~clk;

   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // op stays up so back-to-back calls assign each signal once per step
   task automatic op(input fpu_env_pkg::cmd_type c);
      op_valid = 1'b1;
      op_cmd = c;
      @(negedge clk);
   endtask

   task automatic push(input logic [2:0] t, input logic [79:0] v);
      stack_top = t;
      result_value = v;
      op(fpu_env_pkg::CMD_PUSH);
   endtask

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // hang guard, far above the 46 cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         conclude();
      end
   end

   initial begin
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      op(fpu_env_pkg::CMD_STENV);
      check(save_tag_word, 16'hffff);
      check(save_instr_ptr, 48'h0);
      check(save_status, status_word);
      check(save_control, control_word);
      check(save_valid, 1'b1);
      done("reset");
      // push a normal, a zero and an infinity, then overflow onto slot 5
      push(3'h0, V_ONE);
      check(overflow_pulse, 1'b0);
      push(3'h7, 80'h0);
      push(3'h6, V_INF);
      push(3'h6, V_INF);
      check(overflow_pulse, 1'b1);
      op(fpu_env_pkg::CMD_STENV);
      check(save_tag_word, 16'h1bff);
      // pop onto a full slot, pop onto an empty one, then a full source and an empty one
      stack_top = 3'h4;
      op(fpu_env_pkg::CMD_POP);
      check(underflow_pulse, 1'b0);
      stack_top = 3'h0;
      op(fpu_env_pkg::CMD_POP);
      check(underflow_pulse, 1'b1);
      stack_top = 3'h7;
      src_valid = 1'b1;
      op(fpu_env_pkg::CMD_EXEC);
      check(underflow_pulse, 1'b0);
      src_rel = 3'h2;
      op(fpu_env_pkg::CMD_EXEC);
      check(underflow_pulse, 1'b1);
      src_valid = 1'b0;
      // exec result lands in slot top+1 = 0 as a special value
      result_we = 1'b1;
      result_rel = 3'h1;
      result_value = V_INF;
      op(fpu_env_pkg::CMD_EXEC);
      result_we = 1'b0;
      op(fpu_env_pkg::CMD_STENV);
      check(save_tag_word, 16'h1bfe);
      done("stack");
      prefix_offset = 32'h1234_5678;
      code_selector = 16'h00c8;
      has_mem_operand = 1'b1;
      operand_offset = 32'hdead_beef;
      operand_selector = 16'h0010;
      opcode_first = 8'hd9;
      opcode_second = 8'he8;
      op(fpu_env_pkg::CMD_EXEC);
      // new inputs must not leak in through control operations
      prefix_offset = 32'h0;
      operand_offset = 32'h0;
      opcode_second = 8'h00;
      op(fpu_env_pkg::CMD_STENV);
      for (int i = 0; i < 6; i++) begin
         if (i < 5) op(ctl_tab[i]);
         if (i < 5) op(fpu_env_pkg::CMD_STENV);
         check(save_instr_ptr, IP_EXP);
         check(save_oper_ptr, 48'h0010_dead_beef);
         check(save_opcode, 11'h1e8);
      end
      for (int i = 0; i < 6; i++) begin
         {prot_mode, v86_mode, system_management_mode, op32} = mode_tab[i];
         op(fpu_env_pkg::CMD_STENV);
         check(save_layout, lay_tab[i]);
      end
      done("pointers");
      op(fpu_env_pkg::CMD_SAVE);
      check(save_with_data, 1'b1);
      check(save_tag_word, 16'h1bfe);
      check(save_instr_ptr, IP_EXP);
      op(fpu_env_pkg::CMD_STENV);
      check(save_tag_word, 16'hffff);
      check(save_instr_ptr, 48'h0);
      check(save_oper_ptr, 48'h0);
      check(save_with_data, 1'b0);
      done("save");
      // image claims reg0 normal and reg1 zero: contents decide instead
      CORE.put(0, 80'h0);
      image_tag = 16'hfff4;
      image_instr_ptr = 48'h0123_4567_89ab;
      image_oper_ptr = 48'h0fed_cba9_8765;
      image_opcode = 11'h5a5;
      op(fpu_env_pkg::CMD_LDENV);
      check(reload_data, 1'b0);
      op(fpu_env_pkg::CMD_STENV);
      check(save_tag_word, 16'hfff1);
      check(save_instr_ptr, 48'h0123_4567_89ab);
      check(save_opcode, 11'h5a5);
      op(fpu_env_pkg::CMD_INIT);
      op(fpu_env_pkg::CMD_STENV);
      check(save_tag_word, 16'hffff);
      check(save_oper_ptr, 48'h0);
      image_tag = 16'hfffc;
      op(fpu_env_pkg::CMD_RESTORE);
      check(reload_data, 1'b1);
      op(fpu_env_pkg::CMD_STENV);
      check(save_tag_word, 16'hfffd);
      op_valid = 1'b0;
      done("load");
      @(negedge clk);
      check(save_valid, 1'b0);
      conclude();
   end
endmodule
`default_nettype wire
